//--- hdl/eadec_top.sv
// Effective-address decoder with APB register access and interrupt
//
// Overview of operation
// [RULE1] Full format base-omit bit removes the base register from the address sum.
// [RULE2] Base omitted with data index gives data-register-indirect addressing.
// [RULE3] Full format index-omit bit set drops the index operand.
// [RULE4] Index size 0 sign-extends low word; 1 uses whole long word.
// [RULE5] Base displacement length: 00 reserved, 01 none, 10 word, 11 long.
// [RULE6] Memory-indirect requests trap illegal; index-omit needs select field 000.
// [RULE7] Modes 000 to 110 use the register field as register number.
// [RULE8] Mode 111 register field picks absolute, PC-relative or immediate forms.
// [RULE9] Mode 110 covers brief and full indexed forms, all four categories.
// [RULE10] Classify register direct, indirect, postincrement and predecrement modes.
// [RULE11] Immediate is data and memory; absolute modes are all four categories.
// [RULE12] Control means unsized memory operands; alterable means writable operands.
// [RULE13] Combined categories need membership in both constituent categories.
// [RULE14] Index type bit picks data bank (0) or address bank (1).
// [RULE15] Scale field shifts the index left zero to three bits.
// [RULE16] Absolute short address sign-extends from 16 to 32 bits.
// [RULE17] Long immediate: first word high half; byte immediate uses low byte.
// [RULE18] Extension word bit 8 selects brief (0) or full (1) format.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "eadec_map.svh"
module eadec_top #(
	parameter int DW = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EADEC_AW-1:0] paddr,
	input wire logic [DW-1:0] pwdata,
	output logic [DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic illegal_trap
);
	localparam int HW = DW / 2;
	logic [5:0] ea_word_reg;
	logic [HW-1:0] ext0_reg, ext1_reg, ext2_reg;
	logic [DW-1:0] idxv_reg;
	logic [1:0] imm_size_reg;
	logic [`EADEC_NSTAT-1:0] stat_reg, mask_reg, stat_set;
	eadec_pkg::eadec_state_e state_reg;
	eadec_pkg::eadec_mode_e mode_reg, mode_next;
	eadec_pkg::eadec_cat_s cat_reg, cat_next;
	logic [2:0] regnum_reg, idx_regnum_reg;
	logic full_reg, base_omit_reg, index_omit_reg, idx_addr_bank_reg, idx_long_reg, ill_reg, ill_next;
	logic dreg_ind_reg, dreg_ind_next;
	logic [1:0] scale_reg, bd_len_reg;
	logic [DW-1:0] sidx_reg, opnd_reg, opnd_next, disp_reg, disp_next, sidx_next;
	logic [2:0] ea_mode_f, ea_reg_f, iis_f;
	logic full_f, bs_f, is_f, go_wr, acc, wr, rd;
	logic [1:0] bd_f;
	logic [`EADEC_AW-1:0] addr_l;

	// Category lookup for one decoded mode
	function automatic eadec_pkg::eadec_cat_s eadec_classify(input eadec_pkg::eadec_mode_e m);
		eadec_pkg::eadec_cat_s c;
		c = '0;
		case (m)
			eadec_pkg::MODE_DDIR: c = '{data: 1'b1, mem: 1'b0, ctrl: 1'b0, alter: 1'b1}; // [RULE10]
			eadec_pkg::MODE_ADIR: c = '{data: 1'b0, mem: 1'b0, ctrl: 1'b0, alter: 1'b1}; // [RULE10]
			eadec_pkg::MODE_POST, eadec_pkg::MODE_PRE: c = '{data: 1'b1, mem: 1'b1, ctrl: 1'b0, alter: 1'b1}; // [RULE10]
			eadec_pkg::MODE_AIND, eadec_pkg::MODE_DISP, eadec_pkg::MODE_IDX, eadec_pkg::MODE_ABSW,
			eadec_pkg::MODE_ABSL: c = '{data: 1'b1, mem: 1'b1, ctrl: 1'b1, alter: 1'b1}; // [RULE9] [RULE10] [RULE11]
			eadec_pkg::MODE_PCD, eadec_pkg::MODE_PCX: c = '{data: 1'b1, mem: 1'b0, ctrl: 1'b1, alter: 1'b0}; // [RULE12]
			eadec_pkg::MODE_IMM: c = '{data: 1'b1, mem: 1'b1, ctrl: 1'b0, alter: 1'b0}; // [RULE11]
			default: c = '0;
		endcase
		return c;
	endfunction : eadec_classify

	// Sign extension of a half word
	function automatic logic [DW-1:0] eadec_sext16(input logic [HW-1:0] v);
		return {{HW{v[HW-1]}}, v};
	endfunction : eadec_sext16

	// Bus phase decode
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign go_wr = wr && (paddr == `EADEC_OFF_CTRL) && pwdata[`EADEC_CTRL_GO];
	assign ea_mode_f = ea_word_reg[`EADEC_EA_MODE_HI:`EADEC_EA_MODE_LO];
	assign ea_reg_f = ea_word_reg[`EADEC_EA_REG_HI:`EADEC_EA_REG_LO];
	assign full_f = ext0_reg[`EADEC_X_FULL]; // [RULE18]
	assign bs_f = ext0_reg[`EADEC_X_BS];
	assign is_f = ext0_reg[`EADEC_X_IS];
	assign bd_f = ext0_reg[`EADEC_X_BD_HI:`EADEC_X_BD_LO];
	assign iis_f = ext0_reg[`EADEC_X_IIS_HI:`EADEC_X_IIS_LO];

	// Mode decode and illegal detection
	always_comb begin
		mode_next = eadec_pkg::MODE_BAD;
		case (ea_mode_f)
			`EADEC_M_DDIR: mode_next = eadec_pkg::MODE_DDIR; // [RULE7]
			`EADEC_M_ADIR: mode_next = eadec_pkg::MODE_ADIR;
			`EADEC_M_AIND: mode_next = eadec_pkg::MODE_AIND;
			`EADEC_M_POST: mode_next = eadec_pkg::MODE_POST;
			`EADEC_M_PRE: mode_next = eadec_pkg::MODE_PRE;
			`EADEC_M_DISP: mode_next = eadec_pkg::MODE_DISP;
			`EADEC_M_IDX: mode_next = eadec_pkg::MODE_IDX; // [RULE9]
			default: begin
				case (ea_reg_f)
					`EADEC_R_ABSW: mode_next = eadec_pkg::MODE_ABSW; // [RULE8]
					`EADEC_R_ABSL: mode_next = eadec_pkg::MODE_ABSL;
					`EADEC_R_PCD: mode_next = eadec_pkg::MODE_PCD;
					`EADEC_R_PCX: mode_next = eadec_pkg::MODE_PCX;
					`EADEC_R_IMM: mode_next = eadec_pkg::MODE_IMM;
					default: mode_next = eadec_pkg::MODE_BAD;
				endcase
			end
		endcase
		cat_next = eadec_classify(mode_next);
		ill_next = (mode_next == eadec_pkg::MODE_BAD);
		dreg_ind_next = 1'b0;
		if ((mode_next == eadec_pkg::MODE_IDX || mode_next == eadec_pkg::MODE_PCX) && full_f) begin
			if (iis_f != `EADEC_IIS_NONE || bd_f == `EADEC_BD_RSVD) begin
				ill_next = 1'b1; // [RULE5] [RULE6]
			end
			dreg_ind_next = bs_f && !is_f && !ext0_reg[`EADEC_X_DA]; // [RULE2]
		end
	end

	// Index value sizing and scaling
	eadec_index #(.W(DW)) u_index (
		.raw_value(idxv_reg),
		.long_sel(ext0_reg[`EADEC_X_WL]),
		.scale(ext0_reg[`EADEC_X_SC_HI:`EADEC_X_SC_LO]),
		.omit(full_f && is_f),
		.scaled(sidx_next)
	);

	// Operand and displacement assembly
	always_comb begin
		opnd_next = '0;
		disp_next = '0;
		case (mode_next)
			eadec_pkg::MODE_ABSW: opnd_next = eadec_sext16(ext0_reg); // [RULE16]
			eadec_pkg::MODE_ABSL: opnd_next = {ext0_reg, ext1_reg};
			eadec_pkg::MODE_IMM: begin
				case (imm_size_reg)
					`EADEC_SZ_BYTE: opnd_next = {{(DW-HW/2){1'b0}}, ext0_reg[`EADEC_BYTE_HI:0]}; // [RULE17]
					`EADEC_SZ_WORD: opnd_next = {{HW{1'b0}}, ext0_reg};
					default: opnd_next = {ext0_reg, ext1_reg}; // [RULE17]
				endcase
			end
			default: opnd_next = '0;
		endcase
		if (mode_next == eadec_pkg::MODE_DISP || mode_next == eadec_pkg::MODE_PCD) begin
			disp_next = eadec_sext16(ext0_reg);
		end else if (mode_next == eadec_pkg::MODE_IDX || mode_next == eadec_pkg::MODE_PCX) begin
			if (!full_f) begin
				disp_next = {{(DW-HW/2){ext0_reg[`EADEC_BYTE_HI]}}, ext0_reg[`EADEC_BYTE_HI:0]};
			end else begin
				case (bd_f)
					`EADEC_BD_WORD: disp_next = eadec_sext16(ext1_reg); // [RULE5]
					`EADEC_BD_LONG: disp_next = {ext1_reg, ext2_reg}; // [RULE5]
					default: disp_next = '0;
				endcase
			end
		end
	end

	// Software-written input registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ea_word_reg <= '0;
			ext0_reg <= '0;
			ext1_reg <= '0;
			ext2_reg <= '0;
			idxv_reg <= '0;
			imm_size_reg <= '0;
			mask_reg <= '0;
		end else if (wr) begin
			case (paddr)
				`EADEC_OFF_EA: ea_word_reg <= pwdata[`EADEC_EA_MODE_HI:0];
				`EADEC_OFF_EXT0: ext0_reg <= pwdata[HW-1:0];
				`EADEC_OFF_EXT1: ext1_reg <= pwdata[HW-1:0];
				`EADEC_OFF_EXT2: ext2_reg <= pwdata[HW-1:0];
				`EADEC_OFF_IDXV: idxv_reg <= pwdata;
				`EADEC_OFF_CTRL: imm_size_reg <= pwdata[`EADEC_CTRL_SZ_HI:`EADEC_CTRL_SZ_LO];
				`EADEC_OFF_MASK: mask_reg <= pwdata[`EADEC_NSTAT-1:0];
				default: ;
			endcase
		end
	end

	// Decode sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= eadec_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				eadec_pkg::ST_IDLE: if (go_wr) state_reg <= eadec_pkg::ST_CAPT;
				eadec_pkg::ST_CAPT: state_reg <= eadec_pkg::ST_REPORT;
				eadec_pkg::ST_REPORT: state_reg <= eadec_pkg::ST_IDLE;
				default: state_reg <= eadec_pkg::ST_IDLE;
			endcase
		end
	end

	// Decoded result capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= eadec_pkg::MODE_DDIR;
			cat_reg <= '0;
			regnum_reg <= '0;
			full_reg <= 1'b0;
			base_omit_reg <= 1'b0;
			index_omit_reg <= 1'b0;
			idx_addr_bank_reg <= 1'b0;
			idx_regnum_reg <= '0;
			idx_long_reg <= 1'b0;
			scale_reg <= '0;
			bd_len_reg <= '0;
			ill_reg <= 1'b0;
			dreg_ind_reg <= 1'b0;
			sidx_reg <= '0;
			opnd_reg <= '0;
			disp_reg <= '0;
		end else if (state_reg == eadec_pkg::ST_CAPT) begin
			mode_reg <= mode_next;
			cat_reg <= cat_next;
			regnum_reg <= ea_reg_f; // [RULE7]
			full_reg <= full_f; // [RULE18]
			base_omit_reg <= full_f && bs_f; // [RULE1]
			index_omit_reg <= full_f && is_f; // [RULE3]
			idx_addr_bank_reg <= ext0_reg[`EADEC_X_DA]; // [RULE14]
			idx_regnum_reg <= ext0_reg[`EADEC_X_REG_HI:`EADEC_X_REG_LO]; // [RULE14]
			idx_long_reg <= ext0_reg[`EADEC_X_WL];
			scale_reg <= ext0_reg[`EADEC_X_SC_HI:`EADEC_X_SC_LO];
			bd_len_reg <= full_f ? bd_f : `EADEC_BD_RSVD;
			ill_reg <= ill_next;
			dreg_ind_reg <= dreg_ind_next;
			sidx_reg <= sidx_next;
			opnd_reg <= opnd_next;
			disp_reg <= disp_next;
		end
	end

	// Sticky status, read clears, a new event wins
	assign stat_set = {(state_reg == eadec_pkg::ST_CAPT) && ill_next, state_reg == eadec_pkg::ST_CAPT};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '0;
		end else if (rd && paddr == `EADEC_OFF_STAT) begin
			stat_reg <= (stat_reg & ~prdata[`EADEC_NSTAT-1:0]) | stat_set; // Clear only reported bits
		end else begin
			stat_reg <= stat_reg | stat_set;
		end
	end

	// Interrupt and trap outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			illegal_trap <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
			illegal_trap <= stat_set[`EADEC_ST_ILL]; // [RULE6]
		end
	end

	// APB answer: one access cycle, read data latched in setup
	assign addr_l = paddr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable) begin
				case (addr_l)
					`EADEC_OFF_EA: prdata <= {{(DW-6){1'b0}}, ea_word_reg};
					`EADEC_OFF_EXT0: prdata <= {{HW{1'b0}}, ext0_reg};
					`EADEC_OFF_EXT1: prdata <= {{HW{1'b0}}, ext1_reg};
					`EADEC_OFF_EXT2: prdata <= {{HW{1'b0}}, ext2_reg};
					`EADEC_OFF_IDXV: prdata <= idxv_reg;
					`EADEC_OFF_CTRL: prdata <= {{(DW-3){1'b0}}, imm_size_reg, 1'b0};
					`EADEC_OFF_RES: prdata <= {5'h00, dreg_ind_reg, ill_reg, bd_len_reg, scale_reg, idx_long_reg,
						idx_regnum_reg, idx_addr_bank_reg, index_omit_reg, base_omit_reg, full_reg, regnum_reg,
						cat_reg.alter && cat_reg.data, cat_reg.alter && cat_reg.mem, // [RULE13]
						cat_reg.alter, cat_reg.ctrl, cat_reg.mem, cat_reg.data, mode_reg};
					`EADEC_OFF_SIDX: prdata <= sidx_reg;
					`EADEC_OFF_OPND: prdata <= opnd_reg;
					`EADEC_OFF_DISP: prdata <= disp_reg;
					`EADEC_OFF_STAT: prdata <= {{(DW-`EADEC_NSTAT){1'b0}}, stat_reg};
					`EADEC_OFF_MASK: prdata <= {{(DW-`EADEC_NSTAT){1'b0}}, mask_reg};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Checks on decoded results, decode-done status and interrupt
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ill_mode;
		state_reg == eadec_pkg::ST_CAPT && ea_mode_f == `EADEC_M_EXT && ea_reg_f > `EADEC_R_IMM |=> ill_reg && illegal_trap;
	endproperty
	a_ill_mode: assert property (p_ill_mode) else $error("bad mode not trapped"); // [RULE8]
	property p_mem_ind;
		state_reg == eadec_pkg::ST_CAPT && ea_mode_f == `EADEC_M_IDX && full_f && iis_f != `EADEC_IIS_NONE |=> ill_reg;
	endproperty
	a_mem_ind: assert property (p_mem_ind) else $error("memory indirect not trapped"); // [RULE6]
	property p_imm_cat;
		state_reg == eadec_pkg::ST_REPORT && mode_reg == eadec_pkg::MODE_IMM |-> cat_reg == 4'hC;
	endproperty
	a_imm_cat: assert property (p_imm_cat) else $error("immediate category wrong"); // [RULE11]
	property p_idx_cat;
		state_reg == eadec_pkg::ST_REPORT && mode_reg == eadec_pkg::MODE_IDX |-> cat_reg == 4'hF;
	endproperty
	a_idx_cat: assert property (p_idx_cat) else $error("indexed category wrong"); // [RULE9]
	property p_ddir_cat;
		state_reg == eadec_pkg::ST_REPORT && mode_reg == eadec_pkg::MODE_DDIR |-> cat_reg == 4'h9;
	endproperty
	a_ddir_cat: assert property (p_ddir_cat) else $error("data direct category wrong"); // [RULE10]
	property p_omit_idx;
		state_reg == eadec_pkg::ST_CAPT && full_f && is_f |=> sidx_reg == '0 && index_omit_reg;
	endproperty
	a_omit_idx: assert property (p_omit_idx) else $error("index not dropped"); // [RULE3]
	property p_absw;
		state_reg == eadec_pkg::ST_CAPT && mode_next == eadec_pkg::MODE_ABSW |=>
			opnd_reg == {{HW{$past(ext0_reg[HW-1])}}, $past(ext0_reg)};
	endproperty
	a_absw: assert property (p_absw) else $error("short address not extended"); // [RULE16]
	property p_go_done;
		go_wr && state_reg == eadec_pkg::ST_IDLE |=> ##1 stat_reg[`EADEC_ST_DONE];
	endproperty
	a_go_done: assert property (p_go_done) else $error("decode done not flagged");
	property p_irq;
		|(stat_reg & mask_reg) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : eadec_top

//--- inc/eadec_map.svh
// Register offsets, field positions and codes of the effective-address decoder
`ifndef EADEC_MAP_SVH
`define EADEC_MAP_SVH
`define EADEC_AW 8
`define EADEC_OFF_EA 8'h00
`define EADEC_OFF_EXT0 8'h04
`define EADEC_OFF_EXT1 8'h08
`define EADEC_OFF_EXT2 8'h0C
`define EADEC_OFF_IDXV 8'h10
`define EADEC_OFF_CTRL 8'h14
`define EADEC_OFF_RES 8'h18
`define EADEC_OFF_SIDX 8'h1C
`define EADEC_OFF_OPND 8'h20
`define EADEC_OFF_DISP 8'h24
`define EADEC_OFF_STAT 8'h28
`define EADEC_OFF_MASK 8'h2C
`define EADEC_EA_MODE_HI 5
`define EADEC_EA_MODE_LO 3
`define EADEC_EA_REG_HI 2
`define EADEC_EA_REG_LO 0
`define EADEC_X_DA 15
`define EADEC_X_REG_HI 14
`define EADEC_X_REG_LO 12
`define EADEC_X_WL 11
`define EADEC_X_SC_HI 10
`define EADEC_X_SC_LO 9
`define EADEC_X_FULL 8
`define EADEC_X_BS 7
`define EADEC_X_IS 6
`define EADEC_X_BD_HI 5
`define EADEC_X_BD_LO 4
`define EADEC_X_IIS_HI 2
`define EADEC_X_IIS_LO 0
`define EADEC_BYTE_HI 7
`define EADEC_CTRL_GO 0
`define EADEC_CTRL_SZ_HI 2
`define EADEC_CTRL_SZ_LO 1
`define EADEC_ST_DONE 0
`define EADEC_ST_ILL 1
`define EADEC_NSTAT 2
`define EADEC_M_DDIR 3'h0
`define EADEC_M_ADIR 3'h1
`define EADEC_M_AIND 3'h2
`define EADEC_M_POST 3'h3
`define EADEC_M_PRE 3'h4
`define EADEC_M_DISP 3'h5
`define EADEC_M_IDX 3'h6
`define EADEC_M_EXT 3'h7
`define EADEC_R_ABSW 3'h0
`define EADEC_R_ABSL 3'h1
`define EADEC_R_PCD 3'h2
`define EADEC_R_PCX 3'h3
`define EADEC_R_IMM 3'h4
`define EADEC_BD_RSVD 2'h0
`define EADEC_BD_NULL 2'h1
`define EADEC_BD_WORD 2'h2
`define EADEC_BD_LONG 2'h3
`define EADEC_IIS_NONE 3'h0
`define EADEC_SZ_BYTE 2'h0
`define EADEC_SZ_WORD 2'h1
`define EADEC_SZ_LONG 2'h2
`endif

//--- inc/eadec_pkg.sv
// Types shared by the effective-address decoder files
package eadec_pkg;
	typedef enum logic [3:0] {
		MODE_DDIR = 4'h0, MODE_ADIR = 4'h1, MODE_AIND = 4'h2, MODE_POST = 4'h3,
		MODE_PRE = 4'h4, MODE_DISP = 4'h5, MODE_IDX = 4'h6, MODE_ABSW = 4'h7,
		MODE_ABSL = 4'h8, MODE_PCD = 4'h9, MODE_PCX = 4'hA, MODE_IMM = 4'hB,
		MODE_BAD = 4'hF
	} eadec_mode_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_CAPT = 2'h1, ST_REPORT = 2'h3
	} eadec_state_e;
	typedef struct packed {
		logic data;
		logic mem;
		logic ctrl;
		logic alter;
	} eadec_cat_s;
endpackage : eadec_pkg

//--- hdl/eadec_index.sv
// Index operand sizing, scaling and suppression
`timescale 1ns/1ns
module eadec_index #(
	parameter int W = 32
) (
	input wire logic [W-1:0] raw_value,
	input wire logic long_sel,
	input wire logic [1:0] scale,
	input wire logic omit,
	output logic [W-1:0] scaled
);
	logic [W-1:0] sized;
	// Word index sign-extends, long index passes whole
	always_comb begin
		sized = long_sel ? raw_value : {{(W/2){raw_value[W/2-1]}}, raw_value[W/2-1:0]}; // [RULE4]
		scaled = omit ? '0 : (sized << scale); // [RULE3] [RULE15]
	end
endmodule : eadec_index

//--- verif/tb_eadec_top.sv
// Self-checking bench for the effective-address decoder
`timescale 1ns/1ns
`include "eadec_map.svh"
module tb_eadec_top;
	logic pclk, presetn, psel, penable, pwrite;
	logic [`EADEC_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, res;
	logic pready, pslverr, irq, illegal_trap, err;
	logic [2:0] m, r;
	int mismatches = 0;
	int samples_checked = 0;
	int traps = 0;
	int t0;
	// Expected categories per mode enum, as {alterable, control, memory, data}
	logic [3:0] cat [0:11] = '{4'h9, 4'h8, 4'hF, 4'hB, 4'hB, 4'hF, 4'hF, 4'hF, 4'hF, 4'h5, 4'h5, 4'h3};

	eadec_top #(.DW(32)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.illegal_trap(illegal_trap));

	// Clock at 100 MHz
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Count trap pulses
	always @(posedge pclk) begin
		if (illegal_trap === 1'b1) traps <= traps + 1;
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		end_sim();
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task end_sim();
		if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	// One APB transfer; read data and error taken at the pready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rdchk

	// Load the operands, start a decode, fetch the result word
	task dec(input logic [5:0] ea, input logic [15:0] e0, e1, e2, input logic [31:0] iv, input logic [1:0] sz);
		apb(1'b1, `EADEC_OFF_EA, {26'h0, ea});
		apb(1'b1, `EADEC_OFF_EXT0, {16'h0, e0});
		apb(1'b1, `EADEC_OFF_EXT1, {16'h0, e1});
		apb(1'b1, `EADEC_OFF_EXT2, {16'h0, e2});
		apb(1'b1, `EADEC_OFF_IDXV, iv);
		t0 = traps;
		apb(1'b1, `EADEC_OFF_CTRL, {29'h0, sz, 1'b1});
		repeat (2) @(posedge pclk);
		apb(1'b0, `EADEC_OFF_RES, 32'h0);
		res = rd;
	endtask : dec

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped offset, read-only and pulse registers
		rdchk(`EADEC_OFF_MASK, 32'h0, "mask_reset");
		rdchk(`EADEC_OFF_RES, 32'h0, "res_reset");
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped_rd", {err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, 8'h30, 32'hFFFF_FFFF);
		chk("unmapped_wr_err", err, 1'b1);
		apb(1'b1, `EADEC_OFF_RES, 32'hFFFF_FFFF);
		chk("ro_wr_err", err, 1'b0);
		rdchk(`EADEC_OFF_RES, 32'h0, "ro_kept");
		rdchk(`EADEC_OFF_CTRL, 32'h0, "ctrl_go_reads_0");
		// Every mode and mode-111 selector, plus one unused selector
		for (int i = 0; i < 13; i++) begin
			m = (i < 7) ? i[2:0] : 3'h7;
			r = (i < 7) ? 3'h5 : 3'(i - 7);
			dec({m, r}, 16'h0, 16'h0, 16'h0, 32'h0, 2'h0);
			if (i < 12) begin
				chk("mode", res[3:0], i[3:0]);
				chk("categories", res[7:4], cat[i]);
				chk("alt_mem", res[8], cat[i][3] & cat[i][1]);
				chk("alt_data", res[9], cat[i][3] & cat[i][0]);
				chk("reg_field", res[12:10], r);
			end else begin
				chk("mode_bad", {res[25], res[3:0]}, 5'h1F);
			end
			chk("trap", traps - t0, i == 12);
			rdchk(`EADEC_OFF_STAT, {30'h0, i == 12, 1'b1}, "status");
		end
		// Brief format: word index sign-extended, scale 4, address bank
		dec(6'h32, 16'hB480, 16'h0, 16'h0, 32'h0000_8001, 2'h0);
		chk("brief_fields", res[26:13], {4'h0, 2'h2, 1'b0, 3'h3, 4'h8});
		rdchk(`EADEC_OFF_SIDX, 32'hFFFE_0004, "brief_sidx");
		rdchk(`EADEC_OFF_DISP, 32'hFFFF_FF80, "brief_disp");
		// Full format: base omitted, data index, word displacement, scale 8
		dec(6'h32, 16'h1FA0, 16'h8000, 16'h0, 32'h1000_0001, 2'h0);
		chk("full_bs_fields", res[26:13], {2'h2, 2'h2, 2'h3, 1'b1, 3'h1, 4'h3});
		chk("full_cats", res[9:4], 6'h3F);
		rdchk(`EADEC_OFF_SIDX, 32'h8000_0008, "full_sidx");
		rdchk(`EADEC_OFF_DISP, 32'hFFFF_8000, "bd_word");
		// Full format: index omitted with select 000, long displacement
		dec(6'h32, 16'hF170, 16'h1234, 16'h5678, 32'hFFFF_FFFF, 2'h0);
		chk("full_is_fields", res[26:13], {2'h0, 2'h3, 2'h0, 1'b0, 3'h7, 4'hD});
		chk("is_no_trap", traps - t0, 32'h0);
		rdchk(`EADEC_OFF_SIDX, 32'h0, "is_sidx");
		rdchk(`EADEC_OFF_DISP, 32'h1234_5678, "bd_long");
		// Full format: null displacement, scale 2
		dec(6'h32, 16'h0310, 16'hFFFF, 16'hFFFF, 32'h0000_0010, 2'h0);
		chk("full_null_fields", res[26:13], {2'h0, 2'h1, 2'h1, 1'b0, 3'h0, 4'h1});
		rdchk(`EADEC_OFF_SIDX, 32'h0000_0020, "null_sidx");
		rdchk(`EADEC_OFF_DISP, 32'h0, "bd_null");
		// Memory-indirect, reserved length, index omitted with nonzero select; mode stays indexed
		for (int k = 0; k < 3; k++) begin
			dec(6'h32, (k == 0) ? 16'h0111 : (k == 1) ? 16'h0100 : 16'h0152, 16'h0, 16'h0, 32'h0, 2'h0);
			chk("ill_flag", {res[25], res[3:0]}, 5'h16);
			chk("ill_trap", traps - t0, 32'h1);
		end
		// Absolute, immediate and displacement operands
		dec(6'h38, 16'h8001, 16'h0, 16'h0, 32'h0, 2'h0);
		rdchk(`EADEC_OFF_OPND, 32'hFFFF_8001, "abs_short");
		dec(6'h39, 16'h1234, 16'hABCD, 16'h0, 32'h0, 2'h0);
		rdchk(`EADEC_OFF_OPND, 32'h1234_ABCD, "abs_long");
		dec(6'h3C, 16'hDEAD, 16'hBEEF, 16'h0, 32'h0, 2'h2);
		rdchk(`EADEC_OFF_OPND, 32'hDEAD_BEEF, "imm_long");
		dec(6'h3C, 16'h12A5, 16'h0, 16'h0, 32'h0, 2'h0);
		rdchk(`EADEC_OFF_OPND, 32'h0000_00A5, "imm_byte");
		dec(6'h3C, 16'h8001, 16'h0, 16'h0, 32'h0, 2'h1);
		rdchk(`EADEC_OFF_OPND, 32'h0000_8001, "imm_word");
		dec(6'h2D, 16'h8002, 16'h0, 16'h0, 32'h0, 2'h0);
		rdchk(`EADEC_OFF_DISP, 32'hFFFF_8002, "d16");
		dec(6'h3A, 16'hFFFE, 16'h0, 16'h0, 32'h0, 2'h0);
		rdchk(`EADEC_OFF_DISP, 32'hFFFF_FFFE, "pc_d16");
		// Interrupt: raised when unmasked, cleared by status read, masked off
		apb(1'b0, `EADEC_OFF_STAT, 32'h0);
		apb(1'b1, `EADEC_OFF_MASK, 32'h1);
		rdchk(`EADEC_OFF_MASK, 32'h1, "mask_rw");
		dec(6'h00, 16'h0, 16'h0, 16'h0, 32'h0, 2'h0);
		chk("irq_set", irq, 1'b1);
		rdchk(`EADEC_OFF_STAT, 32'h1, "status_done");
		repeat (2) @(posedge pclk);
		chk("irq_clear", irq, 1'b0);
		rdchk(`EADEC_OFF_STAT, 32'h0, "status_cleared");
		apb(1'b1, `EADEC_OFF_MASK, 32'h2);
		dec(6'h00, 16'h0, 16'h0, 16'h0, 32'h0, 2'h0);
		chk("irq_masked", irq, 1'b0);
		dec(6'h3F, 16'h0, 16'h0, 16'h0, 32'h0, 2'h0);
		chk("irq_illegal", irq, 1'b1);
		rdchk(`EADEC_OFF_STAT, 32'h3, "status_both");
		end_sim();
	end
endmodule : tb_eadec_top
